// file: verilog/grc_cmd_top.sv
`timescale 1ns/100ps
// How it works
// - Real-time read bit 1 set clears the pending interrupt after the reply.
// - Reply packs A and B per channel, channel 1 in low pair.
// - Same real-time bits are sent in the upstream C/I field.
// - Real-time read covers all four channels whatever the address.
// - Mask command 6C writes, 6D reads, one data byte.
// - Mask bit one masks its real-time bit; resets to all ones.
// - Only unmasked bit changes pull the interrupt pin low.
// - Received 80 command bytes load the gain filter coefficient in signed-digit form; other coefficient bytes are only kept.
// - Coefficient read returns up to fourteen bytes, no command echo.
// - Coefficient read may return internal RAM contents for diagnosis.
// - Command 50 writes, 51 reads gain and scaling byte fields.
// - Attenuator on at zero, 6.02 dB gain and loss bits, resets zero.
// - Scaling gain is code minus sixteen, in sixteenths of attenuator gain.
// - Scaling code 10000 selects full digital loopback.
// - Command 80 writes, 81 reads two gain bytes; reset A9F0.
// - Coefficient sign bit zero means plus, one means minus.
// - Transmit gain is one plus nested signed power-of-two terms.
// - Filter-enable selects fixed default or programmed gain coefficient.
// - A is debounced first input, B second or multiplexed first input.
module grc_cmd_top (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_clk_link,
   input wire logic [7:0] i_mon_dn_byte,
   input wire logic i_mon_dn_valid,
   input wire logic i_mon_dn_last,
   input wire logic i_mon_up_ready,
   output logic [7:0] o_mon_up_byte,
   output logic o_mon_up_valid,
   output logic [7:0] o_ci_bits,
   input wire logic [3:0] i_debounced_first_input_bit,
   input wire logic [3:0] i_second_input_bit,
   input wire logic [3:0] i_first_input_mux_bit,
   input wire logic i_mux_en,
   input wire logic i_transmit_gain_coefficient_en,
   output logic o_int_n,
   output logic o_input_attenuator_on,
   output logic o_tx_analog_gain,
   output logic o_rx_analog_loss,
   output logic signed [5:0] o_impedance_scaling_step,
   output logic o_loopback,
   output logic [15:0] o_transmit_gain_filter,
   output logic signed [19:0] o_gx_gain
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [1:0] rst_q;
   logic rst_n;
   grc_xfer_if xfer ();
   logic dn_s1_q;
   logic dn_s2_q;
   logic dn_seen_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic dn_new;
   logic [7:0] dn_byte;
   logic dn_last;
   logic up_tgl_q;
   logic [7:0] up_byte_q;
   logic up_busy;
   grc_pkg::grc_state_t state_q;
   logic [7:0] cmd_q;
   logic [3:0] idx_q;
   logic [3:0] len_q;
   logic cmd_take;
   logic wr_stb;
   logic is_read;
   logic is_write;
   logic gen_d;
   logic cmd_gen;
   logic [3:0] rd_len;
   logic [7:0] reply_byte;
   logic send;
   logic [7:0] rt_d;
   logic [7:0] rt_q;
   logic [7:0] rt_snap_q;
   logic [7:0] signal_interrupt_mask_q;
   logic [7:0] analog_gain_scaling_q;
   logic [15:0] transmit_gain_coefficient_q;
   logic [15:0] gx_sel_q;
   logic [7:0] cop_ram [0:13];
   logic [3:0] cop_cnt_q;
   logic irq_set;
   logic irq_clr;
   logic irq_q;

   // ****************************************
   // Reset release and link side
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_q <= '0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   grc_link u_link (
      .i_clk_link(i_clk_link),
      .i_rst_n(i_rst_n),
      .i_mon_dn_byte(i_mon_dn_byte),
      .i_mon_dn_valid(i_mon_dn_valid),
      .i_mon_dn_last(i_mon_dn_last),
      .i_mon_up_ready(i_mon_up_ready),
      .o_mon_up_byte(o_mon_up_byte),
      .o_mon_up_valid(o_mon_up_valid),
      .o_ci_bits(o_ci_bits),
      .x(xfer.link)
   );

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dn_s1_q <= 1'b0;
         dn_s2_q <= 1'b0;
         dn_seen_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         dn_s1_q <= xfer.dn_tgl;
         dn_s2_q <= dn_s1_q;
         dn_seen_q <= dn_s2_q;
         ack_s1_q <= xfer.up_ack_tgl;
         ack_s2_q <= ack_s1_q;
      end
   end

   assign dn_new = dn_s2_q ^ dn_seen_q;
   assign dn_byte = xfer.dn_hold[7:0];
   assign dn_last = xfer.dn_hold[8];
   assign up_busy = up_tgl_q ^ ack_s2_q;
   assign xfer.up_byte = up_byte_q;
   assign xfer.up_tgl = up_tgl_q;
   assign xfer.ci_bits = rt_q;

   // ****************************************
   // Real-time bits and interrupt
   // ****************************************
   for (genvar c = 0; c < grc_pkg::NCH; c++) begin : g_rt
      assign rt_d[2 * c] = i_debounced_first_input_bit[c];
      assign rt_d[2 * c + 1] = i_mux_en ? i_first_input_mux_bit[c]
                                        : i_second_input_bit[c];
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rt_q <= '0;
      end else begin
         rt_q <= rt_d;
      end
   end

   assign irq_set = |((rt_d ^ rt_q) & ~signal_interrupt_mask_q);
   assign irq_clr = state_q == grc_pkg::ST_REPLY && !up_busy
                    && idx_q == len_q
                    && cmd_q == grc_pkg::CMD_RT_RD_CLR;

   // A new change wins over a clear in the same cycle
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else if (irq_set) begin
         irq_q <= 1'b1;
      end else if (irq_clr) begin
         irq_q <= 1'b0;
      end
   end
   assign o_int_n = ~irq_q;

   // ****************************************
   // Command decode
   // ****************************************
   assign gen_d = dn_byte[grc_pkg::COP_BIT]
                  && dn_byte != grc_pkg::CMD_GX_WR
                  && dn_byte != grc_pkg::CMD_GX_RD;
   assign cmd_gen = cmd_q[grc_pkg::COP_BIT]
                    && cmd_q != grc_pkg::CMD_GX_WR
                    && cmd_q != grc_pkg::CMD_GX_RD;

   always_comb begin
      is_read = 1'b0;
      is_write = 1'b0;
      rd_len = grc_pkg::LEN_ONE;
      if (dn_byte == grc_pkg::CMD_RT_RD
          || dn_byte == grc_pkg::CMD_RT_RD_CLR) begin
         is_read = 1'b1;
      end else if (dn_byte == grc_pkg::CMD_MASK_RD
                   || dn_byte == grc_pkg::CMD_ANA_RD) begin
         is_read = 1'b1;
      end else if (dn_byte == grc_pkg::CMD_GX_RD) begin
         is_read = 1'b1;
         rd_len = grc_pkg::GX_BYTES;
      end else if (dn_byte == grc_pkg::CMD_MASK_WR
                   || dn_byte == grc_pkg::CMD_ANA_WR
                   || dn_byte == grc_pkg::CMD_GX_WR) begin
         is_write = 1'b1;
      end else if (gen_d) begin
         is_read = dn_byte[grc_pkg::RW_BIT];
         is_write = ~dn_byte[grc_pkg::RW_BIT];
         rd_len = cop_cnt_q;
      end
   end

   assign cmd_take = state_q == grc_pkg::ST_CMD && dn_new;
   assign wr_stb = state_q == grc_pkg::ST_DATA && dn_new;

   // ****************************************
   // Message sequencer
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= grc_pkg::ST_ADDR;
         cmd_q <= '0;
         idx_q <= '0;
         len_q <= '0;
      end else begin
         case (state_q)
            grc_pkg::ST_ADDR: begin
               // Address is ignored; all state is device wide
               if (dn_new && !dn_last) begin
                  state_q <= grc_pkg::ST_CMD;
               end
            end
            grc_pkg::ST_CMD: begin
               if (dn_new) begin
                  cmd_q <= dn_byte;
                  idx_q <= '0;
                  len_q <= rd_len;
                  if (is_read) begin
                     state_q <= grc_pkg::ST_REPLY;
                  end else if (dn_last) begin
                     state_q <= grc_pkg::ST_ADDR;
                  end else if (is_write) begin
                     state_q <= grc_pkg::ST_DATA;
                  end else begin
                     state_q <= grc_pkg::ST_DROP;
                  end
               end
            end
            grc_pkg::ST_DATA: begin
               if (dn_new) begin
                  if (idx_q != grc_pkg::COP_MAX) begin
                     idx_q <= idx_q + 4'h1;
                  end
                  if (dn_last) begin
                     state_q <= grc_pkg::ST_ADDR;
                  end
               end
            end
            grc_pkg::ST_REPLY: begin
               if (!up_busy) begin
                  if (idx_q == len_q) begin
                     state_q <= grc_pkg::ST_ADDR;
                  end else begin
                     idx_q <= idx_q + 4'h1;
                  end
               end
            end
            grc_pkg::ST_DROP: begin
               if (dn_new && dn_last) begin
                  state_q <= grc_pkg::ST_ADDR;
               end
            end
            default: begin
               state_q <= grc_pkg::ST_ADDR;
            end
         endcase
      end
   end

   // ****************************************
   // Upstream reply
   // ****************************************
   always_comb begin
      reply_byte = '0;
      if (cmd_q == grc_pkg::CMD_RT_RD
          || cmd_q == grc_pkg::CMD_RT_RD_CLR) begin
         reply_byte = rt_snap_q;
      end else if (cmd_q == grc_pkg::CMD_MASK_RD) begin
         reply_byte = signal_interrupt_mask_q;
      end else if (cmd_q == grc_pkg::CMD_ANA_RD) begin
         reply_byte = analog_gain_scaling_q;
      end else if (cmd_q == grc_pkg::CMD_GX_RD) begin
         reply_byte = idx_q == '0 ? transmit_gain_coefficient_q[15:8]
                                  : transmit_gain_coefficient_q[7:0];
      end else if (cmd_gen) begin
         reply_byte = cop_ram[idx_q];
      end
   end

   assign send = state_q == grc_pkg::ST_REPLY && !up_busy
                 && idx_q != len_q;

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_tgl_q <= 1'b0;
         up_byte_q <= '0;
      end else if (send) begin
         up_tgl_q <= ~up_tgl_q;
         up_byte_q <= reply_byte;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rt_snap_q <= '0;
      end else if (cmd_take) begin
         rt_snap_q <= rt_q;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         signal_interrupt_mask_q <= grc_pkg::MASK_RST;
      end else if (wr_stb && idx_q == '0
                   && cmd_q == grc_pkg::CMD_MASK_WR) begin
         signal_interrupt_mask_q <= dn_byte;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         analog_gain_scaling_q <= grc_pkg::ANA_RST;
      end else if (wr_stb && idx_q == '0
                   && cmd_q == grc_pkg::CMD_ANA_WR) begin
         analog_gain_scaling_q <= dn_byte;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         transmit_gain_coefficient_q <= grc_pkg::GX_ROM;
      end else if (wr_stb && cmd_q == grc_pkg::CMD_GX_WR) begin
         if (idx_q == '0) begin
            transmit_gain_coefficient_q[15:8] <= dn_byte;
         end else if (idx_q == grc_pkg::LEN_ONE) begin
            transmit_gain_coefficient_q[7:0] <= dn_byte;
         end
      end
   end

   // Other coefficient bytes kept for read-back
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cop_cnt_q <= '0;
      end else if (cmd_take && gen_d && is_write) begin
         cop_cnt_q <= '0;
      end else if (wr_stb && cmd_gen && idx_q != grc_pkg::COP_MAX) begin
         cop_cnt_q <= idx_q + 4'h1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (wr_stb && cmd_gen && idx_q != grc_pkg::COP_MAX) begin
         cop_ram[idx_q] <= dn_byte;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gx_sel_q <= grc_pkg::GX_ROM;
      end else if (i_transmit_gain_coefficient_en) begin
         gx_sel_q <= transmit_gain_coefficient_q;
      end else begin
         gx_sel_q <= grc_pkg::GX_ROM;
      end
   end
   assign o_transmit_gain_filter = gx_sel_q;

   grc_gain_eval u_gain (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_coef(gx_sel_q),
      .o_gain(o_gx_gain)
   );

   // ****************************************
   // Analog gain and scaling decode
   // ****************************************
   assign o_input_attenuator_on =
      ~analog_gain_scaling_q[grc_pkg::ANA_DIS_BIT];
   assign o_tx_analog_gain = analog_gain_scaling_q[grc_pkg::ANA_AX_BIT];
   assign o_rx_analog_loss = analog_gain_scaling_q[grc_pkg::ANA_AR_BIT];
   assign o_impedance_scaling_step = $signed(
      {1'b0, analog_gain_scaling_q[grc_pkg::SCL_W-1:0]}
      - grc_pkg::SCL_MID);
   assign o_loopback = analog_gain_scaling_q[grc_pkg::SCL_W-1:0]
                       == grc_pkg::SCL_LOOP;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_mask_rd;
      cmd_take && dn_byte == grc_pkg::CMD_MASK_RD && !up_busy;
   endsequence

   sequence s_clr_done;
      irq_clr && !irq_set;
   endsequence

   mask_reset_a: assert property (
      $rose(rst_n) |-> signal_interrupt_mask_q == grc_pkg::MASK_RST)
      else $error("mask not all ones after reset");

   irq_raise_a: assert property (
      irq_set |=> !o_int_n)
      else $error("unmasked change did not assert interrupt");

   masked_quiet_a: assert property (
      o_int_n && !irq_set |=> o_int_n)
      else $error("interrupt asserted without unmasked change");

   irq_hold_a: assert property (
      !o_int_n && !irq_clr |=> !o_int_n)
      else $error("interrupt dropped without clearing read");

   irq_close_a: assert property (
      s_clr_done |=> o_int_n)
      else $error("clearing read left interrupt pending");

   rt_pack_a: assert property (
      1'b1 |=> rt_q[1:0] == {$past(i_mux_en) ?
         $past(i_first_input_mux_bit[0]) : $past(i_second_input_bit[0]),
         $past(i_debounced_first_input_bit[0])})
      else $error("channel 1 real-time pair packed wrongly");

   mask_reply_a: assert property (
      s_mask_rd |=> ##1 (up_tgl_q != $past(up_tgl_q)
                         && up_byte_q == signal_interrupt_mask_q))
      else $error("mask read did not return mask byte");

   loop_mode_a: assert property (
      wr_stb && cmd_q == grc_pkg::CMD_ANA_WR && idx_q == '0
      && dn_byte[grc_pkg::SCL_W-1:0] == grc_pkg::SCL_LOOP
      |=> o_loopback)
      else $error("scaling code 10000 did not select loopback");

   gx_rom_a: assert property (
      !i_transmit_gain_coefficient_en |=> o_transmit_gain_filter == grc_pkg::GX_ROM)
      else $error("default gain coefficient not selected");
endmodule

// file: inc/grc_pkg.sv
package grc_pkg;
   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_RT_RD = 8'h4D;
   localparam logic [7:0] CMD_RT_RD_CLR = 8'h4F;
   localparam logic [7:0] CMD_MASK_WR = 8'h6C;
   localparam logic [7:0] CMD_MASK_RD = 8'h6D;
   localparam logic [7:0] CMD_ANA_WR = 8'h50;
   localparam logic [7:0] CMD_ANA_RD = 8'h51;
   localparam logic [7:0] CMD_GX_WR = 8'h80;
   localparam logic [7:0] CMD_GX_RD = 8'h81;
   localparam int RW_BIT = 0;
   localparam int COP_BIT = 7;
   // ****************************************
   // Reset values and fields
   // ****************************************
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] ANA_RST = 8'h00;
   localparam logic [15:0] GX_ROM = 16'hA9F0;
   localparam int ANA_DIS_BIT = 7;
   localparam int ANA_AX_BIT = 6;
   localparam int ANA_AR_BIT = 5;
   localparam int SCL_W = 5;
   localparam logic [4:0] SCL_LOOP = 5'h10;
   localparam logic [5:0] SCL_MID = 6'h10;
   localparam int NCH = 4;
   localparam int IDX_W = 4;
   localparam logic [3:0] LEN_ONE = 4'h1;
   localparam logic [3:0] GX_BYTES = 4'h2;
   localparam logic [3:0] COP_MAX = 4'hE;
   // ****************************************
   // Signed-digit evaluation and sequencer states
   // ****************************************
   localparam int GW = 20;
   localparam logic signed [19:0] G_ONE = 20'sh10000;
   localparam int NIB = 4;
   localparam int NIB_W = 4;
   localparam int C_BIT = 3;
   localparam int M_W = 3;
   typedef enum logic [2:0] {
      ST_ADDR = 3'h0,
      ST_CMD = 3'h1,
      ST_DATA = 3'h2,
      ST_REPLY = 3'h3,
      ST_DROP = 3'h4
   } grc_state_t;
endpackage

// file: inc/grc_xfer_if.sv
`timescale 1ns/100ps
interface grc_xfer_if;
   logic [8:0] dn_hold;
   logic dn_tgl;
   logic [7:0] up_byte;
   logic up_tgl;
   logic up_ack_tgl;
   logic [7:0] ci_bits;
   modport link (output dn_hold, dn_tgl, up_ack_tgl,
                 input up_byte, up_tgl, ci_bits);
   modport core (input dn_hold, dn_tgl, up_ack_tgl,
                 output up_byte, up_tgl, ci_bits);
endinterface

// file: verilog/grc_link.sv
`timescale 1ns/100ps
module grc_link (
   input wire logic i_clk_link,
   input wire logic i_rst_n,
   input wire logic [7:0] i_mon_dn_byte,
   input wire logic i_mon_dn_valid,
   input wire logic i_mon_dn_last,
   input wire logic i_mon_up_ready,
   output logic [7:0] o_mon_up_byte,
   output logic o_mon_up_valid,
   output logic [7:0] o_ci_bits,
   grc_xfer_if.link x
);
   logic [1:0] rst_q;
   logic up_s1_q;
   logic up_s2_q;
   logic up_seen_q;
   logic [7:0] ci_s1_q;

   always_ff @(posedge i_clk_link or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_q <= '0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   // ****************************************
   // Downstream bytes, toggle per byte
   // ****************************************
   always_ff @(posedge i_clk_link or negedge rst_q[1]) begin
      if (!rst_q[1]) begin
         x.dn_hold <= '0;
         x.dn_tgl <= 1'b0;
      end else if (i_mon_dn_valid) begin
         x.dn_hold <= {i_mon_dn_last, i_mon_dn_byte};
         x.dn_tgl <= ~x.dn_tgl;
      end
   end

   // ****************************************
   // Upstream bytes, held until taken
   // ****************************************
   always_ff @(posedge i_clk_link or negedge rst_q[1]) begin
      if (!rst_q[1]) begin
         up_s1_q <= 1'b0;
         up_s2_q <= 1'b0;
         up_seen_q <= 1'b0;
         o_mon_up_byte <= '0;
         o_mon_up_valid <= 1'b0;
         x.up_ack_tgl <= 1'b0;
      end else begin
         up_s1_q <= x.up_tgl;
         up_s2_q <= up_s1_q;
         if (!o_mon_up_valid && up_s2_q != up_seen_q) begin
            o_mon_up_byte <= x.up_byte;
            o_mon_up_valid <= 1'b1;
            up_seen_q <= up_s2_q;
         end else if (o_mon_up_valid && i_mon_up_ready) begin
            o_mon_up_valid <= 1'b0;
            x.up_ack_tgl <= ~x.up_ack_tgl;
         end
      end
   end

   // Signalling bits into the upstream C/I field
   always_ff @(posedge i_clk_link or negedge rst_q[1]) begin
      if (!rst_q[1]) begin
         ci_s1_q <= '0;
         o_ci_bits <= '0;
      end else begin
         ci_s1_q <= x.ci_bits;
         o_ci_bits <= ci_s1_q;
      end
   end
endmodule

// file: verilog/grc_gain_eval.sv
`timescale 1ns/100ps
module grc_gain_eval (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [15:0] i_coef,
   output logic signed [19:0] o_gain
);
   function automatic logic signed [19:0] csd_eval(
      input logic [15:0] c
   );
      logic signed [19:0] v;
      logic signed [19:0] t;
      int k;
      v = grc_pkg::G_ONE;
      // Innermost term first, outer one last
      for (k = grc_pkg::NIB - 1; k >= 0; k--) begin
         t = v >>> c[k * grc_pkg::NIB_W +: grc_pkg::M_W];
         if (c[k * grc_pkg::NIB_W + grc_pkg::C_BIT]) begin
            v = grc_pkg::G_ONE - t;
         end else begin
            v = grc_pkg::G_ONE + t;
         end
      end
      return v;
   endfunction

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gain <= grc_pkg::G_ONE;
      end else begin
         o_gain <= csd_eval(i_coef);
      end
   end

   gain_pos_a: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_n)
      (i_coef[3] == 1'b0 && i_coef[7] == 1'b0 && i_coef[11] == 1'b0
       && i_coef[15] == 1'b0) |=> o_gain > grc_pkg::G_ONE)
      else $error("all-plus coefficient gave gain not above one");
endmodule

// file: dv/grc_host_model.sv
`timescale 1ns/100ps
// ****
// Upstream controller on the monitor channel
// ****
module grc_host_model (
   input wire logic i_clk_link,
   input wire logic [7:0] i_up_byte,
   input wire logic i_up_valid,
   output logic [7:0] o_dn_byte,
   output logic o_dn_valid,
   output logic o_dn_last,
   output logic o_up_ready
);
   initial begin
      o_dn_byte = 8'h00;
      o_dn_valid = 1'b0;
      o_dn_last = 1'b0;
      o_up_ready = 1'b0;
   end
   // Address, command, data in order, spaced out
   task automatic send(input logic [7:0] b, input logic l);
      @(negedge i_clk_link);
      o_dn_byte = b;
      o_dn_last = l;
      o_dn_valid = 1'b1;
      @(negedge i_clk_link);
      o_dn_valid = 1'b0;
      o_dn_byte = ~b;
      o_dn_last = ~l;
      repeat (4) @(negedge i_clk_link);
   endtask
   // Takes one reply byte; stays unknown on timeout
   task automatic recv(output logic [7:0] r);
      r = 8'hXX;
      for (int i = 0; i < 300; i++) begin
         @(posedge i_clk_link);
         if (i_up_valid === 1'b1) break;
      end
      @(negedge i_clk_link);
      o_up_ready = 1'b1;
      @(posedge i_clk_link);
      if (i_up_valid === 1'b1) r = i_up_byte;
      @(negedge i_clk_link);
      o_up_ready = 1'b0;
   endtask
endmodule

// file: dv/gci_rtdata_irq_coef_cmds_test.sv
`timescale 1ns/100ps
module gci_rtdata_irq_coef_cmds_test;
   logic i_clk_sys = 1'b0;
   logic i_clk_link = 1'b0;
   logic i_rst_n, i_mon_dn_valid, i_mon_dn_last, i_mon_up_ready, o_mon_up_valid;
   logic [7:0] i_mon_dn_byte, o_mon_up_byte, o_ci_bits;
   logic [3:0] i_debounced_first_input_bit, i_second_input_bit;
   logic [3:0] i_first_input_mux_bit;
   logic i_mux_en, i_transmit_gain_coefficient_en, o_int_n, o_input_attenuator_on;
   logic o_tx_analog_gain, o_rx_analog_loss, o_loopback;
   logic signed [5:0] o_impedance_scaling_step;
   logic [15:0] o_transmit_gain_filter, v;
   logic signed [19:0] o_gx_gain;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   initial begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #7;
      forever #62.5 i_clk_link = ~i_clk_link;
   end
   grc_cmd_top dut (.i_clk_sys, .i_rst_n, .i_clk_link, .i_mon_dn_byte,
      .i_mon_dn_valid, .i_mon_dn_last, .i_mon_up_ready, .o_mon_up_byte,
      .o_mon_up_valid, .o_ci_bits, .i_debounced_first_input_bit,
      .i_second_input_bit, .i_first_input_mux_bit, .i_mux_en,
      .i_transmit_gain_coefficient_en, .o_int_n, .o_input_attenuator_on, .o_tx_analog_gain,
      .o_rx_analog_loss, .o_impedance_scaling_step, .o_loopback,
      .o_transmit_gain_filter, .o_gx_gain);
   grc_host_model m (.i_clk_link, .i_up_byte(o_mon_up_byte),
      .i_up_valid(o_mon_up_valid), .o_dn_byte(i_mon_dn_byte),
      .o_dn_valid(i_mon_dn_valid), .o_dn_last(i_mon_dn_last),
      .o_up_ready(i_mon_up_ready));
   // ****
   // Tasks
   // ****
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
      m.send(8'h03, 1'b0);
      m.send(c, 1'b0);
      if (n == 2) m.send(d[15:8], 1'b0);
      m.send(d[7:0], 1'b1);
      wt(1);
   endtask
   task automatic rd(input logic [7:0] c, input int n);
      logic [7:0] b;
      v = 16'h0000;
      m.send(8'h03, 1'b0);
      m.send(c, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.recv(b);
         v = {v[7:0], b};
      end
      wt(1);
   endtask
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         stop_test();
      end
   end
   // ****
   // Tests
   // ****
   initial begin
      i_rst_n = 1'b0;
      i_debounced_first_input_bit = 4'h0;
      i_second_input_bit = 4'h0;
      i_first_input_mux_bit = 4'h0;
      i_mux_en = 1'b0;
      i_transmit_gain_coefficient_en = 1'b0;
      wt(4);
      i_rst_n = 1'b1;
      wt(40);
      chk(16'({o_int_n, o_input_attenuator_on, o_loopback,
         o_impedance_scaling_step}), 16'h01B0);
      chk(o_gx_gain[19:4], 16'h1FEC);
      rd(8'h6D, 1);
      chk(v, 16'h00FF);
      rd(8'h51, 1);
      chk(v, 16'h0000);
      rd(8'h81, 2);
      chk(v, 16'hA9F0);
      chk(o_transmit_gain_filter, 16'hA9F0);
      $display("test reset values done");
      wr(8'h6C, 1, 16'h00FD);
      rd(8'h6D, 1);
      chk(v, 16'h00FD);
      i_second_input_bit = 4'h1;
      wt(3);
      chk(16'(o_int_n), 16'h0000);
      rd(8'h4D, 1);
      chk(v, 16'h0002);
      wt(10);
      chk(16'(o_int_n), 16'h0000);
      rd(8'h4F, 1);
      chk(v, 16'h0002);
      wt(10);
      chk(16'(o_int_n), 16'h0001);
      i_debounced_first_input_bit = 4'h2;
      wt(4);
      chk(16'(o_int_n), 16'h0001);
      repeat (6) @(negedge i_clk_link);
      chk(16'(o_ci_bits), 16'h0006);
      wt(1);
      i_mux_en = 1'b1;
      wt(3);
      chk(16'(o_int_n), 16'h0000);
      rd(8'h4F, 1);
      chk(v, 16'h0004);
      $display("test interrupt done");
      wr(8'h50, 1, 16'h0010);
      wt(4);
      chk(16'(o_loopback), 16'h0001);
      wr(8'h50, 1, 16'h00E3);
      wt(4);
      chk(16'({o_input_attenuator_on, o_tx_analog_gain, o_rx_analog_loss,
         o_impedance_scaling_step}), 16'h00F3);
      rd(8'h51, 1);
      chk(v, 16'h00E3);
      $display("test analog done");
      wr(8'h80, 2, 16'h1234);
      i_transmit_gain_coefficient_en = 1'b1;
      wt(4);
      chk(o_transmit_gain_filter, 16'h1234);
      chk(o_gx_gain[19:4], 16'h112C);
      rd(8'h81, 2);
      chk(v, 16'h1234);
      i_transmit_gain_coefficient_en = 1'b0;
      wt(3);
      chk(o_transmit_gain_filter, 16'hA9F0);
      $display("test gain coefficient done");
      wr(8'h82, 2, 16'h5A3C);
      rd(8'h83, 2);
      chk(v, 16'h5A3C);
      $display("test generic coefficient done");
      stop_test();
   end
endmodule
